// ---- core/gmw_pkg.sv ----
// package for the two-bit port, pin mode and oscillator sequencing block
// assumes a 50 MHz system clock and a byte-wide register port from the serial bus logic
package gmw_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] ADDR_PORT_OUT = 8'h40;
  localparam logic [7:0] ADDR_PORT_IN = 8'h41;
  localparam logic [7:0] ADDR_MODE = 8'h70;

  // ==========================================================================
  // field positions
  localparam int OUT_DATA_LSB = 0;
  localparam int OUT_DIR_LSB = 4;
  localparam int MODE_REF_OUT_PIN0 = 0;
  localparam int MODE_REF_IN_PIN1 = 1;
  localparam int MODE_PUMP_FORCE_DIS = 2;
  localparam int MODE_PUMP_FORCE_EN = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] PORT_OUT_RST = 8'h30;
  localparam logic [7:0] MODE_RST = 8'h00;

  // ==========================================================================
  // timing
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int OSC_HZ = 4_000_000;
  localparam int OSC_DIV = SYS_CLK_HZ / OSC_HZ / 2;
  localparam int BOOT_US = 800;
  localparam int WAKE_US = 450;
  localparam int BOOT_CYC = BOOT_US * (SYS_CLK_HZ / 1_000_000);
  localparam int WAKE_CYC = WAKE_US * (SYS_CLK_HZ / 1_000_000);
  localparam int CNT_W = 16;
  localparam int IDLE_SLEEP_CYC = 1024;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_SLEEP,
    ST_WAKE,
    ST_RUN
  } gmw_state_t;

endpackage

// ---- core/gmw_gpio_mode_wake.sv ----
// two-bit port with direction control, pin mode overrides, pump force bits and oscillator sequencing
// assumes the serial bus logic presents byte writes and reads as single-cycle strobes on CLK_SYS

// What this block does
// - a pin whose direction bit is 1 has both its input path and its output driver enabled.
// - a pin whose direction bit is 0 is input only with its driver off.
// - every direction bit resets to 1.
// - the pin levels are readable at 0x41 and writes there do nothing.
// - input reads return the pin level with no filtering.
// - the input path stays active while a pin drives, so the real level reads back.
// - each driving pin follows its low data bit of the register at 0x40.
// - output data bits reset to 0.
// - a set reference routing bit at 0x70 removes the pin's digital function.
// - force-disable alone keeps the pump off with the supply routed straight through.
// - force-enable keeps the pump on whatever force-disable says.
// - the oscillator clock is the 50 MHz system clock divided by 12, about 4.17 MHz.
// - after reset the oscillator runs to load trims, then stops and the block sleeps.
// - reset to sleep completes within 800 us.
// - bus traffic in sleep restarts the oscillator within 450 us.
// - no conversion may begin while the oscillator restarts.
module gmw_gpio_mode_wake #(
  parameter int BOOT_CYCLES = gmw_pkg::BOOT_CYC,
  parameter int WAKE_CYCLES = gmw_pkg::WAKE_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic BUS_ACTIVITY,
  input wire logic CONV_REQ,
  output logic CONV_START,
  input wire logic [1:0] PORT_PIN_I,
  output logic [1:0] PORT_PIN_O,
  output logic [1:0] PORT_PIN_OE,
  output logic [1:0] PORT_PIN_IE,
  output logic REFERENCE_OUT_ON_PIN_ZERO,
  output logic REFERENCE_IN_ON_PIN_ONE,
  output logic PUMP_ENABLE,
  output logic PUMP_BYPASS,
  output logic OSC_RUN,
  output logic OSC_CLK,
  output logic TRIM_LOAD,
  output logic CLOCKS_READY
);

  // ==========================================================================
  // registers
  logic [7:0] port_out_r, port_out_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  always_comb
  begin
    port_out_nxt = port_out_r;
    mode_nxt = mode_r;
    rdata_nxt = rdata_r;
    if (REG_WR && hit(REG_ADDR, gmw_pkg::ADDR_PORT_OUT))
    begin
      port_out_nxt = REG_WDATA;
    end
    if (REG_WR && hit(REG_ADDR, gmw_pkg::ADDR_MODE))
    begin
      mode_nxt = REG_WDATA;
    end
    // a read in the same cycle as a write returns the old value
    if (REG_RD)
    begin
      if (hit(REG_ADDR, gmw_pkg::ADDR_PORT_OUT))
      begin
        rdata_nxt = port_out_r;
      end
      else if (hit(REG_ADDR, gmw_pkg::ADDR_PORT_IN))
      begin
        rdata_nxt = {6'h00, PORT_PIN_I};
      end
      else if (hit(REG_ADDR, gmw_pkg::ADDR_MODE))
      begin
        rdata_nxt = mode_r;
      end
      else
      begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      port_out_r <= gmw_pkg::PORT_OUT_RST;
      mode_r <= gmw_pkg::MODE_RST;
      rdata_r <= 8'h00;
    end
    else
    begin
      port_out_r <= port_out_nxt;
      mode_r <= mode_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // pin drivers
  logic [1:0] pin_o_r, pin_o_nxt;
  logic [1:0] pin_oe_r, pin_oe_nxt;
  logic [1:0] pin_ie_r, pin_ie_nxt;
  logic [1:0] analog_sel;
  logic ref_out_r, ref_in_r, pump_en_r, pump_byp_r;
  logic ref_out_nxt, ref_in_nxt, pump_en_nxt, pump_byp_nxt;

  always_comb
  begin
    analog_sel = {mode_r[gmw_pkg::MODE_REF_IN_PIN1], mode_r[gmw_pkg::MODE_REF_OUT_PIN0]};
    ref_out_nxt = analog_sel[0];
    ref_in_nxt = analog_sel[1];
    pump_en_nxt = mode_r[gmw_pkg::MODE_PUMP_FORCE_EN];
    pump_byp_nxt = mode_r[gmw_pkg::MODE_PUMP_FORCE_DIS] && !mode_r[gmw_pkg::MODE_PUMP_FORCE_EN];
  end

  // analog routing takes the pin away from both buffers
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      always_comb
      begin
        pin_o_nxt[g] = port_out_r[gmw_pkg::OUT_DATA_LSB + g];
        pin_oe_nxt[g] = port_out_r[gmw_pkg::OUT_DIR_LSB + g] && !analog_sel[g];
        pin_ie_nxt[g] = !analog_sel[g];
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      pin_o_r <= 2'h0;
      pin_oe_r <= 2'h0;
      pin_ie_r <= 2'h0;
      ref_out_r <= 1'b0;
      ref_in_r <= 1'b0;
      pump_en_r <= 1'b0;
      pump_byp_r <= 1'b0;
    end
    else
    begin
      pin_o_r <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
      pin_ie_r <= pin_ie_nxt;
      ref_out_r <= ref_out_nxt;
      ref_in_r <= ref_in_nxt;
      pump_en_r <= pump_en_nxt;
      pump_byp_r <= pump_byp_nxt;
    end
  end

  // ==========================================================================
  // oscillator sequencing
  // the divided clock is parked low in sleep so no runt edge leaks out
  gmw_pkg::gmw_state_t state_r, state_nxt;
  logic [gmw_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [3:0] div_r, div_nxt;
  logic osc_clk_r, osc_clk_nxt;
  logic conv_r, conv_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1;
    conv_nxt = 1'b0;
    unique case (state_r)
      gmw_pkg::ST_BOOT:
      begin
        if (cnt_r >= gmw_pkg::CNT_W'(BOOT_CYCLES - 1))
        begin
          state_nxt = gmw_pkg::ST_SLEEP;
          cnt_nxt = '0;
        end
      end
      // counter parked at zero so the restart count starts clean
      gmw_pkg::ST_SLEEP:
      begin
        cnt_nxt = '0;
        if (BUS_ACTIVITY)
        begin
          state_nxt = gmw_pkg::ST_WAKE;
        end
      end
      // conversions stay blocked until the restart count expires
      gmw_pkg::ST_WAKE:
      begin
        if (cnt_r >= gmw_pkg::CNT_W'(WAKE_CYCLES - 1))
        begin
          state_nxt = gmw_pkg::ST_RUN;
          cnt_nxt = '0;
        end
      end
      // bus traffic or a conversion request restarts the idle count
      gmw_pkg::ST_RUN:
      begin
        conv_nxt = CONV_REQ;
        if (BUS_ACTIVITY || CONV_REQ)
        begin
          cnt_nxt = '0;
        end
        else if (cnt_r >= gmw_pkg::CNT_W'(gmw_pkg::IDLE_SLEEP_CYC - 1))
        begin
          state_nxt = gmw_pkg::ST_SLEEP;
          cnt_nxt = '0;
        end
      end
    endcase
    // oscillator approximated as an even division of the system clock
    div_nxt = div_r + 1'b1;
    osc_clk_nxt = osc_clk_r;
    if (state_r == gmw_pkg::ST_SLEEP)
    begin
      div_nxt = 4'h0;
      osc_clk_nxt = 1'b0;
    end
    else if (div_r >= 4'(gmw_pkg::OSC_DIV - 1))
    begin
      div_nxt = 4'h0;
      osc_clk_nxt = !osc_clk_r;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state_r <= gmw_pkg::ST_BOOT;
      cnt_r <= '0;
      div_r <= 4'h0;
      osc_clk_r <= 1'b0;
      conv_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      osc_clk_r <= osc_clk_nxt;
      conv_r <= conv_nxt;
    end
  end

  // ==========================================================================
  // status outputs
  logic osc_run_r, trim_r, ready_r;
  logic osc_run_nxt, trim_nxt, ready_nxt;

  always_comb
  begin
    osc_run_nxt = (state_nxt != gmw_pkg::ST_SLEEP);
    trim_nxt = (state_nxt == gmw_pkg::ST_BOOT);
    ready_nxt = (state_nxt == gmw_pkg::ST_RUN);
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      osc_run_r <= 1'b0;
      trim_r <= 1'b0;
      ready_r <= 1'b0;
    end
    else
    begin
      osc_run_r <= osc_run_nxt;
      trim_r <= trim_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign REG_RDATA = rdata_r;
  assign PORT_PIN_O = pin_o_r;
  assign PORT_PIN_OE = pin_oe_r;
  assign PORT_PIN_IE = pin_ie_r;
  assign REFERENCE_OUT_ON_PIN_ZERO = ref_out_r;
  assign REFERENCE_IN_ON_PIN_ONE = ref_in_r;
  assign PUMP_ENABLE = pump_en_r;
  assign PUMP_BYPASS = pump_byp_r;
  assign OSC_RUN = osc_run_r;
  assign OSC_CLK = osc_clk_r;
  assign TRIM_LOAD = trim_r;
  assign CLOCKS_READY = ready_r;
  assign CONV_START = conv_r;

endmodule

// ---- verification/gmw_pin_model.sv ----
// partner: external circuits on the two port pins
// assumes the split output, enable and input of the block
module gmw_pin_model (
  input wire logic [1:0] oe,
  input wire logic [1:0] o,
  input wire logic [1:0] ext,
  output logic [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // a driven pin shows the driver, else the outside level
  assign pin = (oe & o) | (~oe & ext);
endmodule

// ---- verification/gmw_chk_props.sv ----
// checker: port, mode and sleep/wake properties
// assumes binding onto the gpio block, sync reset
module gmw_chk #(
  parameter int BOOT_CYCLES = 20,
  parameter int WAKE_CYCLES = 10
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic CONV_START,
  input wire logic [1:0] PORT_PIN_I,
  input wire logic [1:0] PORT_PIN_O,
  input wire logic [1:0] PORT_PIN_OE,
  input wire logic REFERENCE_OUT_ON_PIN_ZERO,
  input wire logic REFERENCE_IN_ON_PIN_ONE,
  input wire logic PUMP_ENABLE,
  input wire logic PUMP_BYPASS,
  input wire logic OSC_RUN,
  input wire logic OSC_CLK,
  input wire logic TRIM_LOAD,
  input wire logic CLOCKS_READY
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BOOT_MAX = BOOT_CYCLES + 8;
  localparam int WAKE_MAX = WAKE_CYCLES + 8;
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  // =====
  // sequences
  sequence wr_out_s;
    REG_WR && REG_ADDR == 8'h40 && !REFERENCE_OUT_ON_PIN_ZERO && !REFERENCE_IN_ON_PIN_ONE;
  endsequence
  sequence boot_s;
    TRIM_LOAD && OSC_RUN ##[1:BOOT_MAX] !OSC_RUN && !TRIM_LOAD;
  endsequence
  sequence wake_s;
    $rose(OSC_RUN) && !TRIM_LOAD;
  endsequence
  // =====
  // properties
  dir_write_a: assert property (wr_out_s |=> ##1 PORT_PIN_OE == $past(REG_WDATA[5:4], 2))
    else $error("direction write");
  data_write_a: assert property (wr_out_s |=> ##1 PORT_PIN_O == $past(REG_WDATA[1:0], 2))
    else $error("data write");
  in_read_a: assert property (REG_RD && REG_ADDR == 8'h41 |=> REG_RDATA == {6'h00, $past(PORT_PIN_I)})
    else $error("input read");
  ref_pin_a: assert property (REFERENCE_OUT_ON_PIN_ZERO |-> !PORT_PIN_OE[0])
    else $error("reference pin");
  pump_off_a: assert property (REG_WR && REG_ADDR == 8'h70 && REG_WDATA[3:2] == 2'b01 |=> ##1 PUMP_BYPASS && !PUMP_ENABLE)
    else $error("pump off");
  rst_pins_a: assert property ($fell(SYS_RST) |=> PORT_PIN_OE == 2'b11 && PORT_PIN_O == 2'b00)
    else $error("reset pins");
  boot_seq_a: assert property ($fell(SYS_RST) |=> boot_s)
    else $error("boot");
  wake_time_a: assert property (wake_s |-> ##[1:WAKE_MAX] CLOCKS_READY)
    else $error("wake time");
  wake_conv_a: assert property (wake_s |-> !CONV_START [*8])
    else $error("start in wake");
  osc_sleep_a: assert property (!OSC_RUN && !$past(OSC_RUN) |-> !OSC_CLK)
    else $error("clock in sleep");
  osc_period_a: assert property (disable iff (SYS_RST || !OSC_RUN) $rose(OSC_CLK) |-> OSC_CLK [*6] ##1 !OSC_CLK)
    else $error("clock period");
endmodule

bind gmw_gpio_mode_wake gmw_chk #(.BOOT_CYCLES(BOOT_CYCLES), .WAKE_CYCLES(WAKE_CYCLES)) u_chk (.CLK_SYS(CLK_SYS),
  .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .CONV_START(CONV_START), .PORT_PIN_I(PORT_PIN_I), .PORT_PIN_O(PORT_PIN_O),
  .PORT_PIN_OE(PORT_PIN_OE), .REFERENCE_OUT_ON_PIN_ZERO(REFERENCE_OUT_ON_PIN_ZERO),
  .REFERENCE_IN_ON_PIN_ONE(REFERENCE_IN_ON_PIN_ONE), .PUMP_ENABLE(PUMP_ENABLE), .PUMP_BYPASS(PUMP_BYPASS),
  .OSC_RUN(OSC_RUN), .OSC_CLK(OSC_CLK), .TRIM_LOAD(TRIM_LOAD), .CLOCKS_READY(CLOCKS_READY));

// ---- verification/testbench.sv ----
// testbench: register access, pins, mode table, sleep and wake
// assumes the bound checker and the pin partner model
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, act = 1'b0, req = 1'b0;
  logic [7:0] a = 8'h00, wd = 8'h00, rdat;
  logic [1:0] ext = 2'b11, pin, po, oe, ie;
  logic cs, r0, r1, pe, pb, osc, cr;
  logic [3:0] m;
  int miscompares = 0;
  int checked = 0;
  gmw_gpio_mode_wake #(.BOOT_CYCLES(20), .WAKE_CYCLES(10)) dut (.CLK_SYS(clk), .SYS_RST(rst),
    .REG_WR(wr), .REG_RD(rd), .REG_ADDR(a), .REG_WDATA(wd), .REG_RDATA(rdat), .BUS_ACTIVITY(act),
    .CONV_REQ(req), .CONV_START(cs), .PORT_PIN_I(pin), .PORT_PIN_O(po), .PORT_PIN_OE(oe),
    .PORT_PIN_IE(ie), .REFERENCE_OUT_ON_PIN_ZERO(r0), .REFERENCE_IN_ON_PIN_ONE(r1), .PUMP_ENABLE(pe),
    .PUMP_BYPASS(pb), .OSC_RUN(osc), .OSC_CLK(), .TRIM_LOAD(), .CLOCKS_READY(cr));
  gmw_pin_model pm (.oe(oe), .o(po), .ext(ext), .pin(pin));
  initial forever #10 clk = ~clk;
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wrt(input logic [7:0] ad, input logic [7:0] dt);
    a <= ad;
    wd <= dt;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic rdr(input logic [7:0] ad, input logic [7:0] exp);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk("rdata", rdat, exp);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // tests take about 1200 cycles
  initial
  begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset pins", {4'h0, oe, po}, 8'h0c);
    rdr(8'h40, 8'h30);
    rdr(8'h70, 8'h00);
    $display("reset done");
    wrt(8'h40, 8'h12);
    chk("drive", {4'h0, oe, po}, 8'h06);
    rdr(8'h41, 8'h02);
    wrt(8'h41, 8'hff);
    rdr(8'h41, 8'h02);
    rdr(8'h55, 8'h00);
    wrt(8'h40, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      ext <= i[1:0];
      rdr(8'h41, {6'h00, i[1:0]});
    end
    $display("port done");
    wrt(8'h40, 8'h30);
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:0];
      wrt(8'h70, {4'h0, m});
      chk("mode", {oe, ie, r1, r0, pe, pb}, {~m[1:0], ~m[1:0], m[1:0], m[3], m[2] & ~m[3]});
    end
    wrt(8'h70, 8'h00);
    $display("mode done");
    for (int k = 0; k < 100 && osc; k++)
      @(posedge clk);
    chk("asleep", {7'h00, osc}, 8'h00);
    req <= 1'b1;
    repeat (4) @(posedge clk);
    chk("start asleep", {7'h00, cs}, 8'h00);
    act <= 1'b1;
    @(posedge clk);
    act <= 1'b0;
    for (int k = 0; k < 40 && !cr; k++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    chk("wake run", {6'h00, cr, cs}, 8'h03);
    req <= 1'b0;
    $display("wake done");
    repeat (1020) @(posedge clk);
    chk("idle run", {6'h00, osc, cs}, 8'h02);
    repeat (6) @(posedge clk);
    chk("idle sleep", {6'h00, osc, cs}, 8'h00);
    $display("idle done");
    end_of_test();
  end
endmodule
